// ### logic/rap_defs.svh
`ifndef RAP_DEFS_SVH
`define RAP_DEFS_SVH

// ============================================================
// Clock and core timing, in picoseconds.
`define RAP_TCK_PS 10000
`define RAP_READ_TO_PRECHARGE_MIN_TIME_PS 7500
`define RAP_TRP_PS 12500
`define RAP_ROW_ACTIVE_MIN_TIME_PS 40000

// ============================================================
// Derived clock counts, rounded up to whole cycles.
`define RAP_RTP_CK ((`RAP_READ_TO_PRECHARGE_MIN_TIME_PS + `RAP_TCK_PS - 1) / `RAP_TCK_PS)
`define RAP_RP_CK ((`RAP_TRP_PS + `RAP_TCK_PS - 1) / `RAP_TCK_PS)
`define RAP_RAS_CK ((`RAP_ROW_ACTIVE_MIN_TIME_PS + `RAP_TCK_PS - 1) / `RAP_TCK_PS)
`define RAP_RTPRP_CK ((`RAP_READ_TO_PRECHARGE_MIN_TIME_PS + `RAP_TRP_PS + `RAP_TCK_PS - 1) / `RAP_TCK_PS)
// Internal precharge start is floored at two clocks past the last prefetch.
`define RAP_MIN_RTP_PS (`RAP_MIN_RTP_CK * `RAP_TCK_PS)
`define RAP_AP_FLOOR_PS (`RAP_READ_TO_PRECHARGE_MIN_TIME_PS > `RAP_MIN_RTP_PS ? `RAP_READ_TO_PRECHARGE_MIN_TIME_PS : `RAP_MIN_RTP_PS)
`define RAP_APRP_CK ((`RAP_AP_FLOOR_PS + `RAP_TRP_PS + `RAP_TCK_PS - 1) / `RAP_TCK_PS)
`define RAP_MIN_RTP_CK 2
`define RAP_LAST_PREFETCH_CK 2
`define RAP_WR_EXTRA_CK 2

// ============================================================
// Link geometry and read-pipe depth.
`define RAP_BANKS 8
`define RAP_COL_W 10
`define RAP_PIPE_DEPTH 20

`endif

// ### logic/rap_pkg.sv
package rap_pkg;
	typedef enum logic [2:0] {
		RAP_NOP = 3'b000,
		RAP_ACT = 3'b001,
		RAP_RD = 3'b010,
		RAP_PRE = 3'b011,
		RAP_WR = 3'b100
	} rap_cmd_e;

	typedef enum logic [1:0] {
		RAP_IDLE = 2'b00,
		RAP_OPEN = 2'b01,
		RAP_AP_WAIT = 2'b10,
		RAP_PRECHG = 2'b11
	} rap_bank_e;
endpackage : rap_pkg

// ### logic/rap_link_if.sv
`timescale 1ns/1ps
`include "rap_defs.svh"

interface rap_link_if;
	rap_pkg::rap_cmd_e cmd;
	logic [2:0] bank;
	logic [`RAP_COL_W-1:0] col;
	logic auto_precharge_select_line;
	logic [31:0] dq;
	logic lower_byte_strobe;
	logic upper_byte_strobe;

	modport dram (
		input cmd, bank, col, auto_precharge_select_line,
		output dq, lower_byte_strobe, upper_byte_strobe
	);
	modport ctrl (
		output cmd, bank, col, auto_precharge_select_line,
		input dq, lower_byte_strobe, upper_byte_strobe
	);
endinterface : rap_link_if

// ### logic/rap_dram_end.sv
`timescale 1ns/1ps
`include "rap_defs.svh"

module rap_dram_end #(
	parameter bit WIDE = 1'b1
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Mode settings.
	input wire logic [2:0] i_additive_latency,
	input wire logic [2:0] i_column_latency,
	input wire logic i_burst_length_8,
	// Link.
	rap_link_if.dram link,
	// Status.
	output logic o_ap_start,
	output logic [2:0] o_ap_bank,
	output logic [`RAP_BANKS-1:0] o_bank_open,
	output logic [`RAP_BANKS-1:0] o_bank_prechg
);
	localparam int NB = `RAP_BANKS;
	localparam int DEPTH = `RAP_PIPE_DEPTH;
	localparam logic [19:0] TCK = 20'(`RAP_TCK_PS);

	if (`RAP_READ_TO_PRECHARGE_MIN_TIME_PS + `RAP_TRP_PS + 16 * `RAP_TCK_PS >= 2 ** 20) begin : g_bad_timing
		$error("Timing figures overflow the picosecond counters.");
	end

	function automatic logic [19:0] dec_ps(input logic [19:0] v);
		dec_ps = (v > TCK) ? 20'(v - TCK) : 20'h0_0000;
	endfunction : dec_ps

	// ============================================================
	// Bank timing state.
	rap_pkg::rap_bank_e st [NB];
	rap_pkg::rap_bank_e next_st [NB];
	logic [19:0] ras_left [NB], next_ras_left [NB];
	logic [19:0] rtp_left [NB], next_rtp_left [NB];
	logic [19:0] pre_left [NB], next_pre_left [NB];
	logic [4:0] ap_cnt [NB], next_ap_cnt [NB];
	logic next_ap_start;
	logic [2:0] next_ap_bank;
	logic [4:0] half;
	logic [19:0] w;

	always_comb begin
		half = i_burst_length_8 ? 5'h0_4 : 5'h0_2;
		next_ap_start = 1'b0;
		next_ap_bank = 3'h0;
		w = 20'h0_0000;
		for (int b = 0; b < NB; b++) begin
			next_st[b] = st[b];
			next_ras_left[b] = dec_ps(ras_left[b]);
			next_rtp_left[b] = dec_ps(rtp_left[b]);
			next_pre_left[b] = dec_ps(pre_left[b]);
			next_ap_cnt[b] = ap_cnt[b];
			case (st[b])
				rap_pkg::RAP_IDLE: begin
					if (link.cmd == rap_pkg::RAP_ACT && link.bank == 3'(b)) begin
						next_st[b] = rap_pkg::RAP_OPEN;
						next_ras_left[b] = 20'(`RAP_ROW_ACTIVE_MIN_TIME_PS);
					end
				end
				rap_pkg::RAP_OPEN: begin
					if (link.cmd == rap_pkg::RAP_RD && link.bank == 3'(b)) begin
						// Read-to-precharge runs from the last 4-bit prefetch edge.
						next_rtp_left[b] = 20'(`RAP_READ_TO_PRECHARGE_MIN_TIME_PS) + 20'(TCK * 20'(
							{2'b00, i_additive_latency} + half - 5'(`RAP_LAST_PREFETCH_CK))); // R15
						if (link.auto_precharge_select_line) begin // R1 R9
							next_st[b] = rap_pkg::RAP_AP_WAIT;
							next_ap_cnt[b] = {2'b00, i_additive_latency} + half; // R2 R8
						end
					end else if (link.cmd == rap_pkg::RAP_PRE && link.bank == 3'(b)) begin
						next_st[b] = rap_pkg::RAP_PRECHG;
						next_pre_left[b] = 20'(`RAP_TRP_PS);
					end
				end
				rap_pkg::RAP_AP_WAIT: begin
					if (ap_cnt[b] > 5'h0_1) begin
						next_ap_cnt[b] = ap_cnt[b] - 5'h0_1;
					end else begin
						// Remaining row-active or read-to-precharge time at this edge.
						w = (next_ras_left[b] > next_rtp_left[b]) ?
							next_ras_left[b] : next_rtp_left[b]; // R3
						if (w < TCK) begin
							next_st[b] = rap_pkg::RAP_PRECHG;
							next_pre_left[b] = 20'(`RAP_TRP_PS) + w; // R4
							next_ap_start = 1'b1; // R2
							next_ap_bank = 3'(b);
						end
					end
				end
				rap_pkg::RAP_PRECHG: begin
					if (next_pre_left[b] == 20'h0_0000) begin
						// The precharge is over by this edge, so an activate here is legal.
						if (link.cmd == rap_pkg::RAP_ACT && link.bank == 3'(b)) begin
							next_st[b] = rap_pkg::RAP_OPEN;
							next_ras_left[b] = 20'(`RAP_ROW_ACTIVE_MIN_TIME_PS);
						end else begin
							next_st[b] = rap_pkg::RAP_IDLE;
						end
					end
				end
				default: next_st[b] = rap_pkg::RAP_IDLE;
			endcase
		end
	end

	// ============================================================
	// Read data pipe: one entry per clock, two beats each.
	logic pv [DEPTH], next_pv [DEPTH];
	logic [`RAP_COL_W-1:0] pcol [DEPTH], next_pcol [DEPTH];
	logic [2:0] pbank [DEPTH], next_pbank [DEPTH];
	logic [4:0] rl;
	logic [31:0] next_dq;
	logic next_lower_stb;
	logic next_upper_stb;

	always_comb begin
		rl = {2'b00, i_additive_latency} + {2'b00, i_column_latency}; // R14
		for (int i = 0; i < DEPTH; i++) begin
			next_pv[i] = (i < DEPTH - 1) ? pv[(i + 1) % DEPTH] : 1'b0;
			next_pcol[i] = pcol[(i + 1) % DEPTH];
			next_pbank[i] = pbank[(i + 1) % DEPTH];
			if (link.cmd == rap_pkg::RAP_RD && 5'(i) >= rl - 5'h0_1 &&
				5'(i) < rl - 5'h0_1 + half) begin // R14
				next_pv[i] = 1'b1;
				next_pcol[i] = link.col + `RAP_COL_W'(2 * (5'(i) - rl + 5'h0_1));
				next_pbank[i] = link.bank;
			end
		end
		next_dq = pv[0] ? {2'b00, pbank[0], pcol[0] + `RAP_COL_W'(1), 1'b1,
			2'b00, pbank[0], pcol[0], 1'b0} : 32'h0000_0000;
		next_lower_stb = pv[0]; // R13
		next_upper_stb = pv[0] & WIDE; // R13
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int b = 0; b < NB; b++) begin
				st[b] <= rap_pkg::RAP_IDLE;
				ras_left[b] <= 20'h0_0000;
				rtp_left[b] <= 20'h0_0000;
				pre_left[b] <= 20'h0_0000;
				ap_cnt[b] <= 5'h0_0;
			end
			for (int i = 0; i < DEPTH; i++) begin
				pv[i] <= 1'b0;
				pcol[i] <= '0;
				pbank[i] <= 3'h0;
			end
			o_ap_start <= 1'b0;
			o_ap_bank <= 3'h0;
			link.dq <= 32'h0000_0000;
			link.lower_byte_strobe <= 1'b0;
			link.upper_byte_strobe <= 1'b0;
		end else begin
			st <= next_st;
			ras_left <= next_ras_left;
			rtp_left <= next_rtp_left;
			pre_left <= next_pre_left;
			ap_cnt <= next_ap_cnt;
			pv <= next_pv;
			pcol <= next_pcol;
			pbank <= next_pbank;
			o_ap_start <= next_ap_start;
			o_ap_bank <= next_ap_bank;
			link.dq <= next_dq;
			link.lower_byte_strobe <= next_lower_stb;
			link.upper_byte_strobe <= next_upper_stb;
		end
	end

	for (genvar b = 0; b < NB; b++) begin : g_stat
		assign o_bank_open[b] = (st[b] == rap_pkg::RAP_OPEN || st[b] == rap_pkg::RAP_AP_WAIT);
		assign o_bank_prechg[b] = (st[b] == rap_pkg::RAP_PRECHG);
	end
endmodule : rap_dram_end

// ### logic/rap_ctrl_end.sv
`timescale 1ns/1ps
`include "rap_defs.svh"

// Notes on behaviour
// (R1) Read with select line high arms auto precharge.
// (R2) Auto precharge starts additive latency plus half-burst later.
// (R3) Unmet row-active or read-to-precharge postpones that start.
// (R4) Precharge period counts from the true start instant.
// (R5) Four-beat: reactivate after latency plus rounded sum.
// (R6) Eight-beat: same, plus two more clocks.
// (R7) Combined period rounds up to whole clocks.
// (R8) Never precharge within two clocks of last prefetch.
// (R9) Auto-precharge reads allowed while other banks active.
// (R10) Cross-bank gaps: half-burst, plus two, one.
// (R11) Explicit precharge waits for row-active minimum.
// (R12) Read-to-precharge spacing uses larger of rounded times.
// (R13) Wide part: each byte lane has own strobe.
// (R14) Read data follows additive plus column latency.
// (R15) Read-to-precharge measured from last prefetch edge.
// (R16) Per-bank counters; auto-precharged bank counts closed.
module rap_ctrl_end #(
	parameter int CNT_W = 6
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Mode settings.
	input wire logic [2:0] i_additive_latency,
	input wire logic [2:0] i_column_latency,
	input wire logic i_burst_length_8,
	// Command request.
	input wire logic i_req_valid,
	input wire rap_pkg::rap_cmd_e i_req_cmd,
	input wire logic [2:0] i_req_bank,
	input wire logic [`RAP_COL_W-1:0] i_req_col,
	input wire logic i_req_auto_precharge,
	output logic o_req_ready,
	// Read data.
	output logic o_rd_valid,
	output logic [31:0] o_rd_data,
	output logic [1:0] o_rd_lanes,
	// Link.
	rap_link_if.ctrl link,
	// Status.
	output logic [`RAP_BANKS-1:0] o_bank_open
);
	localparam int NB = `RAP_BANKS;

	if (CNT_W < 5 || `RAP_RAS_CK + `RAP_RP_CK >= 2 ** CNT_W) begin : g_bad_cnt_w
		$error("CNT_W too small for the timing counts.");
	end

	function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
		dec = (v != '0) ? CNT_W'(v - 1'b1) : '0;
	endfunction : dec

	function automatic logic [CNT_W-1:0] load(input logic [CNT_W-1:0] n);
		load = (n != '0) ? CNT_W'(n - 1'b1) : '0;
	endfunction : load

	function automatic logic [CNT_W-1:0] max2(input logic [CNT_W-1:0] a,
		input logic [CNT_W-1:0] b);
		max2 = (a > b) ? a : b;
	endfunction : max2

	// ============================================================
	// Timing figures in clocks for the current mode.
	logic [CNT_W-1:0] half;
	logic [CNT_W-1:0] base;
	logic [CNT_W-1:0] rd_to_pre;
	logic [CNT_W-1:0] rda_to_act;

	always_comb begin
		half = i_burst_length_8 ? CNT_W'(4) : CNT_W'(2);
		// Edge of the last 4-bit prefetch, counted from the read.
		base = CNT_W'(i_additive_latency) + half - CNT_W'(`RAP_LAST_PREFETCH_CK); // R15
		rd_to_pre = base + max2(CNT_W'(`RAP_RTP_CK), CNT_W'(`RAP_MIN_RTP_CK)); // R12
		// Four-beat: base equals additive latency; eight-beat adds two. The internal
		// precharge never starts before two clocks past the last prefetch, so that floor
		// enters the rounded sum as well.
		rda_to_act = base + CNT_W'(`RAP_APRP_CK); // R5 R6 R7 R8
	end

	// ============================================================
	// Per-bank and cross-bank counters.
	logic open_q [NB], next_open [NB];
	logic [CNT_W-1:0] act_wait [NB], next_act_wait [NB];
	logic [CNT_W-1:0] pre_wait [NB], next_pre_wait [NB];
	logic [CNT_W-1:0] ras_wait [NB], next_ras_wait [NB];
	logic [CNT_W-1:0] rd_gap, next_rd_gap;
	logic [CNT_W-1:0] wr_gap, next_wr_gap;
	logic [CNT_W-1:0] any_gap, next_any_gap;
	logic legal;
	logic take;
	logic [2:0] rb;

	always_comb begin
		rb = i_req_bank;
		case (i_req_cmd)
			rap_pkg::RAP_ACT: begin
				legal = !open_q[rb] && act_wait[rb] == '0 && any_gap == '0; // R16 R10
			end
			rap_pkg::RAP_RD: begin
				legal = open_q[rb] && rd_gap == '0; // R9 R10
			end
			rap_pkg::RAP_WR: begin
				legal = open_q[rb] && wr_gap == '0; // R10
			end
			rap_pkg::RAP_PRE: begin
				legal = open_q[rb] && ras_wait[rb] == '0 && pre_wait[rb] == '0 &&
					any_gap == '0; // R11 R12
			end
			rap_pkg::RAP_NOP: legal = 1'b1;
			default: legal = 1'b0;
		endcase
		o_req_ready = legal;
		take = i_req_valid && legal;
	end

	always_comb begin
		next_rd_gap = dec(rd_gap);
		next_wr_gap = dec(wr_gap);
		next_any_gap = dec(any_gap);
		for (int b = 0; b < NB; b++) begin
			next_open[b] = open_q[b];
			next_act_wait[b] = dec(act_wait[b]);
			next_pre_wait[b] = dec(pre_wait[b]);
			next_ras_wait[b] = dec(ras_wait[b]);
			if (take && rb == 3'(b)) begin
				case (i_req_cmd)
					rap_pkg::RAP_ACT: begin
						next_open[b] = 1'b1;
						next_ras_wait[b] = load(CNT_W'(`RAP_RAS_CK)); // R11
					end
					rap_pkg::RAP_RD: begin
						next_pre_wait[b] = load(rd_to_pre); // R12
						if (i_req_auto_precharge) begin // R1
							// Closed at once; reopen waits for the hidden precharge.
							next_open[b] = 1'b0; // R16
							next_act_wait[b] = load(max2(rda_to_act,
								dec(ras_wait[b]) + CNT_W'(`RAP_RP_CK) + 1'b1)); // R5 R6 R16
						end
					end
					rap_pkg::RAP_PRE: begin
						next_open[b] = 1'b0;
						next_act_wait[b] = load(CNT_W'(`RAP_RP_CK));
					end
					default: next_open[b] = open_q[b];
				endcase
			end
		end
		if (take && i_req_cmd == rap_pkg::RAP_RD) begin
			next_rd_gap = load(half); // R10
			next_wr_gap = load(half + CNT_W'(`RAP_WR_EXTRA_CK)); // R10
			next_any_gap = load(CNT_W'(1)); // R10
		end else if (take && i_req_cmd != rap_pkg::RAP_NOP) begin
			next_any_gap = load(CNT_W'(1));
			if (i_req_cmd == rap_pkg::RAP_WR) begin
				next_rd_gap = load(half);
				next_wr_gap = load(half);
			end
		end
	end

	// ============================================================
	// Link command and captured read data, next values.
	rap_pkg::rap_cmd_e next_cmd;
	logic [2:0] next_bank;
	logic [`RAP_COL_W-1:0] next_col;
	logic next_ap_sel;
	logic next_rd_valid;
	logic [31:0] next_rd_data;
	logic [1:0] next_rd_lanes;

	always_comb begin
		next_cmd = take ? i_req_cmd : rap_pkg::RAP_NOP;
		next_bank = take ? i_req_bank : 3'h0;
		next_col = take ? i_req_col : '0;
		next_ap_sel = take && i_req_auto_precharge && i_req_cmd == rap_pkg::RAP_RD; // R1
		next_rd_valid = link.lower_byte_strobe | link.upper_byte_strobe; // R14
		// Each byte lane is kept only under its own strobe.
		next_rd_data = link.dq & {{8{link.upper_byte_strobe}}, {8{link.lower_byte_strobe}},
			{8{link.upper_byte_strobe}}, {8{link.lower_byte_strobe}}}; // R13
		next_rd_lanes = {link.upper_byte_strobe, link.lower_byte_strobe}; // R13
	end

	// ============================================================
	// Registers: counters, link command and captured read data.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int b = 0; b < NB; b++) begin
				open_q[b] <= 1'b0;
				act_wait[b] <= '0;
				pre_wait[b] <= '0;
				ras_wait[b] <= '0;
			end
			rd_gap <= '0;
			wr_gap <= '0;
			any_gap <= '0;
			link.cmd <= rap_pkg::RAP_NOP;
			link.bank <= 3'h0;
			link.col <= '0;
			link.auto_precharge_select_line <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= 32'h0000_0000;
			o_rd_lanes <= 2'h0;
		end else begin
			open_q <= next_open;
			act_wait <= next_act_wait;
			pre_wait <= next_pre_wait;
			ras_wait <= next_ras_wait;
			rd_gap <= next_rd_gap;
			wr_gap <= next_wr_gap;
			any_gap <= next_any_gap;
			link.cmd <= next_cmd;
			link.bank <= next_bank;
			link.col <= next_col;
			link.auto_precharge_select_line <= next_ap_sel;
			o_rd_valid <= next_rd_valid;
			o_rd_data <= next_rd_data;
			o_rd_lanes <= next_rd_lanes;
		end
	end

	for (genvar b = 0; b < NB; b++) begin : g_open
		assign o_bank_open[b] = open_q[b];
	end
endmodule : rap_ctrl_end

// ### verification/rap_read_ap_monitor.sv
`timescale 1ns/1ps
`include "rap_defs.svh"

module rap_read_ap_monitor (
	// Clock, reset and mode.
	input logic i_clk,
	input logic i_rst,
	input logic [2:0] i_additive_latency,
	input logic [2:0] i_column_latency,
	input logic i_burst_length_8,
	// Link.
	input rap_pkg::rap_cmd_e cmd,
	input logic [2:0] bank,
	input logic auto_precharge_select_line,
	input logic [31:0] dq,
	input logic lower_byte_strobe,
	input logic upper_byte_strobe,
	// Device status.
	input logic o_ap_start,
	input logic [2:0] o_ap_bank
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// ============================================================
	// Clocks since the last command seen on the link, saturating.
	logic [`RAP_BANKS-1:0][5:0] act_age, next_act_age, rd_age, next_rd_age;
	logic [`RAP_BANKS-1:0] ap_pend, next_ap_pend;
	logic [5:0] last_rd, next_last_rd, half, ap_due, act_min, pre_min;
	logic [31:0] exp_stb, next_exp_stb;
	logic ap_late;

	assign half = i_burst_length_8 ? 6'h04 : 6'h02;
	assign ap_due = 6'(i_additive_latency) + half;
	assign act_min = ap_due - 6'h02 + 6'(`RAP_RTPRP_CK);
	assign pre_min = ap_due - 6'h02
		+ 6'(`RAP_RTP_CK > `RAP_MIN_RTP_CK ? `RAP_RTP_CK : `RAP_MIN_RTP_CK);

	function automatic logic [5:0] bump(input logic [5:0] a);
		return (a == 6'h00 || a == 6'h3f) ? a : a + 6'h01;
	endfunction : bump

	always_comb begin
		next_last_rd = bump(last_rd);
		next_exp_stb = exp_stb >> 1;
		next_ap_pend = ap_pend;
		ap_late = 1'b0;
		for (int b = 0; b < `RAP_BANKS; b++) begin
			next_act_age[b] = bump(act_age[b]);
			next_rd_age[b] = bump(rd_age[b]);
			if (ap_pend[b] && rd_age[b] > ap_due + 6'h01 && act_age[b] > 6'(`RAP_RAS_CK + 1)) begin
				ap_late = 1'b1;
			end
		end
		if (o_ap_start) begin
			next_ap_pend[o_ap_bank] = 1'b0;
		end
		if (cmd == rap_pkg::RAP_ACT) begin
			next_act_age[bank] = 6'h01;
			next_rd_age[bank] = 6'h00;
		end
		if (cmd == rap_pkg::RAP_RD) begin
			next_rd_age[bank] = 6'h01;
			next_last_rd = 6'h01;
			next_ap_pend[bank] = next_ap_pend[bank] | auto_precharge_select_line;
			next_exp_stb = next_exp_stb | (((32'h0000_0001 << half) - 32'h0000_0001)
				<< (5'(i_additive_latency) + 5'(i_column_latency)));
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			act_age <= '0;
			rd_age <= '0;
			ap_pend <= '0;
			last_rd <= '0;
			exp_stb <= '0;
		end else begin
			act_age <= next_act_age;
			rd_age <= next_rd_age;
			ap_pend <= next_ap_pend;
			last_rd <= next_last_rd;
			exp_stb <= next_exp_stb;
		end
	end

	// ============================================================
	// Checks.
	ap_not_early_a:
		assert property (o_ap_start |-> ap_pend[o_ap_bank] && rd_age[o_ap_bank] > ap_due
			&& act_age[o_ap_bank] > 6'(`RAP_RAS_CK)) else $error("auto precharge too early");
	ap_not_late_a:
		assert property (!ap_late) else $error("auto precharge too late");
	act_gap_a:
		assert property (cmd == rap_pkg::RAP_ACT |-> (rd_age[bank] == 6'h00 || rd_age[bank] >= act_min)
			&& (act_age[bank] == 6'h00 || act_age[bank] >= 6'(`RAP_RAS_CK + `RAP_RP_CK)))
			else $error("activate too soon");
	pre_gap_a:
		assert property (cmd == rap_pkg::RAP_PRE |-> act_age[bank] >= 6'(`RAP_RAS_CK)
			&& (rd_age[bank] == 6'h00 || rd_age[bank] >= pre_min)) else $error("precharge too soon");
	rd_gap_a:
		assert property (cmd == rap_pkg::RAP_RD && last_rd != 6'h00 |-> last_rd >= half)
			else $error("read too soon");
	wr_gap_a:
		assert property (cmd == rap_pkg::RAP_WR && last_rd != 6'h00 |-> last_rd >= half + 6'h02)
			else $error("write too soon");
	strobe_time_a:
		assert property (lower_byte_strobe == exp_stb[0]) else $error("strobe at wrong clock");
	lanes_pair_a:
		assert property (lower_byte_strobe == upper_byte_strobe && (lower_byte_strobe ? (!dq[0]
			&& dq[16] && dq[26:17] == dq[10:1] + 10'h001) : dq == 32'h0000_0000))
			else $error("byte lanes mismatched");

	cover property (o_ap_start && act_age[o_ap_bank] == 6'h05);
	cover property (cmd == rap_pkg::RAP_RD && auto_precharge_select_line && i_burst_length_8);
	cover property (cmd == rap_pkg::RAP_RD && last_rd == half);
endmodule : rap_read_ap_monitor

// ### verification/read_auto_precharge_timing_tb.sv
`timescale 1ns/1ps
`include "rap_defs.svh"

module read_auto_precharge_timing_tb;
	// ============================================================
	// Stimulus and design.
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [2:0] al = 3'h0;
	logic [2:0] cl = 3'h3;
	logic bl8 = 1'b0;
	logic req_valid = 1'b0;
	rap_pkg::rap_cmd_e req_cmd = rap_pkg::RAP_NOP;
	logic [2:0] req_bank = 3'h0;
	logic [9:0] c = 10'h000;
	logic req_ap = 1'b0;
	logic req_ready, rd_valid, ap_start;
	logic [31:0] rd_data;
	logic [1:0] rd_lanes;
	logic [2:0] ap_bank, b;
	logic [7:0] ctrl_open, dram_open, dram_prechg;
	logic [33:0] exp_q[$];
	int num_errors = 0;
	int checked = 0;
	int ap_sent = 0;
	int ap_seen = 0;

	initial begin
		forever #5 i_clk = ~i_clk;
	end

	rap_link_if link ();
	rap_dram_end #(.WIDE(1'b1)) i_rap_dram_end (.i_clk, .i_rst, .i_additive_latency(al),
		.i_column_latency(cl), .i_burst_length_8(bl8), .link(link), .o_ap_start(ap_start),
		.o_ap_bank(ap_bank), .o_bank_open(dram_open), .o_bank_prechg(dram_prechg));
	rap_ctrl_end #(.CNT_W(6)) i_rap_ctrl_end (.i_clk, .i_rst, .i_additive_latency(al),
		.i_column_latency(cl), .i_burst_length_8(bl8), .i_req_valid(req_valid),
		.i_req_cmd(req_cmd), .i_req_bank(req_bank), .i_req_col(c), .i_req_auto_precharge(req_ap),
		.o_req_ready(req_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
		.o_rd_lanes(rd_lanes), .link(link), .o_bank_open(ctrl_open));
	rap_read_ap_monitor i_rap_read_ap_monitor (.i_clk, .i_rst, .i_additive_latency(al),
		.i_column_latency(cl), .i_burst_length_8(bl8), .cmd(link.cmd), .bank(link.bank),
		.auto_precharge_select_line(link.auto_precharge_select_line), .dq(link.dq),
		.lower_byte_strobe(link.lower_byte_strobe), .upper_byte_strobe(link.upper_byte_strobe),
		.o_ap_start(ap_start), .o_ap_bank(ap_bank));

	// ============================================================
	// Checking and driving.
	task automatic give_verdict;
		if (num_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [33:0] seen, input logic [33:0] want);
		checked++;
		if (seen !== want) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check

	function automatic logic [33:0] beat(input logic [2:0] bk, input logic [9:0] col, input int j);
		logic [9:0] cj;
		cj = col + 10'(2 * j);
		return {2'h3, 2'h0, bk, cj + 10'h001, 1'b1, 2'h0, bk, cj, 1'b0};
	endfunction : beat

	// The request is held until the edge that takes it; the next may follow at once.
	task automatic issue(input rap_pkg::rap_cmd_e cmd, input logic [2:0] bk, input logic ap);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_cmd <= cmd;
		req_bank <= bk;
		req_ap <= ap;
		@(negedge i_clk);
		while (req_ready !== 1'b1) begin
			n++;
			if (n > 300) begin
				check(34'h0, 34'h1);
				give_verdict();
			end
			@(negedge i_clk);
		end
		@(posedge i_clk);
		if (cmd == rap_pkg::RAP_RD) begin
			ap_sent += int'(ap);
			for (int j = 0; j < (bl8 ? 4 : 2); j++) begin
				exp_q.push_back(beat(bk, c, j));
			end
		end
	endtask : issue

	always @(posedge i_clk) begin
		if (!i_rst && rd_valid === 1'b1) begin
			check({rd_lanes, rd_data}, exp_q.size() > 0 ? exp_q.pop_front() : 34'hx);
		end
		if (!i_rst && ap_start === 1'b1) begin
			ap_seen++;
			check({33'h0, dram_prechg[ap_bank]}, 34'h1);
		end
	end

	initial begin
		void'($urandom(32'h0000_ad73));
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		// A read to a closed bank is refused.
		req_valid <= 1'b1;
		req_cmd <= rap_pkg::RAP_RD;
		@(negedge i_clk);
		check({26'h0, ctrl_open}, {26'h0, dram_open});
		check({33'h0, req_ready}, 34'h0);
		@(posedge i_clk);
		req_valid <= 1'b0;
		@(posedge i_clk);
		for (int m = 0; m < 6; m++) begin
			if (m > 0) begin
				i_rst <= 1'b1;
				al <= 3'($urandom % 6);
				cl <= 3'(3 + $urandom % 4);
				bl8 <= m[0];
				repeat (2) @(posedge i_clk);
				i_rst <= 1'b0;
			end
			b = 3'($urandom % 8);
			c = 10'($urandom) & 10'h3f0;
			issue(rap_pkg::RAP_ACT, b ^ 3'h1, 1'b0);
			issue(rap_pkg::RAP_ACT, b, 1'b0);
			issue(rap_pkg::RAP_RD, b, 1'b1);
			issue(rap_pkg::RAP_RD, b ^ 3'h1, 1'b0);
			issue(rap_pkg::RAP_WR, b ^ 3'h1, 1'b0);
			issue(rap_pkg::RAP_PRE, b ^ 3'h1, 1'b0);
			issue(rap_pkg::RAP_ACT, b, 1'b0);
			issue(rap_pkg::RAP_RD, b, 1'b1);
			req_valid <= 1'b0;
			for (int n = 0; exp_q.size() != 0 || ctrl_open !== 8'h00 || dram_open !== 8'h00; n++) begin
				if (n > 300) begin
					check(34'h0, 34'h1);
					give_verdict();
				end
				@(negedge i_clk);
			end
			repeat (4) @(posedge i_clk);
			check(34'(ap_seen), 34'(ap_sent));
		end
		give_verdict();
	end
endmodule : read_auto_precharge_timing_tb
